// ==== include/hlr_pkg.sv ====
package hlr_pkg;
  // Register word indexes on the Avalon-MM slave (byte address is 4x).
  localparam logic [3:0] REG_DATA      = 4'h0;
  localparam logic [3:0] REG_ERR_FEAT  = 4'h1;
  localparam logic [3:0] REG_SECCNT    = 4'h2;
  localparam logic [3:0] REG_SECNUM    = 4'h3;
  localparam logic [3:0] REG_CYL_LO    = 4'h4;
  localparam logic [3:0] REG_CYL_HI    = 4'h5;
  localparam logic [3:0] REG_DEV_HEAD  = 4'h6;
  localparam logic [3:0] REG_STAT_CMD  = 4'h7;
  localparam logic [3:0] REG_CONTROL   = 4'h8;
  localparam logic [3:0] REG_OFF_CAPS  = 4'h9;
  localparam logic [3:0] REG_HLTH_CAPS = 4'hA;

  // Command keys.
  localparam logic [7:0] CMD_HEALTH    = 8'hB0;
  localparam logic [7:0] FEAT_READ_LOG = 8'hD5;
  localparam logic [7:0] KEY_CYL_LO    = 8'h4F;
  localparam logic [7:0] KEY_CYL_HI    = 8'hC2;

  // Log addresses.
  localparam logic [7:0] LOG_DIR       = 8'h00;
  localparam logic [7:0] LOG_ERROR     = 8'h01;
  localparam logic [7:0] LOG_SELFTEST  = 8'h06;
  localparam logic [7:0] LOG_HOST_LO   = 8'h80;
  localparam logic [7:0] LOG_HOST_HI   = 8'h9F;
  localparam logic [7:0] LOG_VEND_LO   = 8'hA0;
  localparam logic [7:0] LOG_VEND_HI   = 8'hBF;
  localparam logic [7:0] LOG_VERSION   = 8'h01;
  localparam logic [4:0] HOST_SECT_MULTI = 5'h10;

  // Status and error bit positions.
  localparam int ST_BSY  = 7;
  localparam int ST_DRIVE_READY_FLAG = 6;
  localparam int ST_DF   = 5;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  localparam int ER_UNC  = 6;
  localparam int ER_ID_NOT_FOUND_FLAG = 4;
  localparam int ER_ABORTED_FLAG = 2;
  localparam int DH_DEV  = 4;

  // Capability fields.
  localparam int OC_RUN_NOW   = 0;
  localparam int OC_ABORT_NEW = 2;
  localparam int OC_SCAN      = 3;
  localparam int OC_SELFTEST  = 4;
  localparam int HC_PWR_SAVE  = 0;
  localparam int HC_AUTOSAVE  = 1;
  localparam logic [15:0] OFF_DUR_MIN = 16'h0001;

  localparam logic [9:0] SECT_LAST = 10'h1FF;
  localparam int ABORT_LIMIT_S = 2;
  localparam longint CLK_HZ = 200000000;

  typedef enum logic [1:0] {
    HLR_IDLE  = 2'b00,
    HLR_CHECK = 2'b01,
    HLR_XFER  = 2'b11
  } hlr_state_e;
endpackage

// ==== src/hlr_top.sv ====
// Operation
// [RULE1] Off-line duration word is never zero.
// [RULE2] Capability bit 0 marks run-now support.
// [RULE3] Bit 2 set: new command aborts off-line work.
// [RULE4] Bit 2 clear: new command suspends off-line work.
// [RULE5] Bits 3, 4 advertise scanning and self-test.
// [RULE6] Health bit 0 advertises power-mode data saving.
// [RULE7] Health bit 1 always one, rest reserved.
// [RULE8] Host waits polling time before polling.
// [RULE9] Byte 511 makes the sector sum zero; the code does so only for error and self-test logs, directory byte 511 is 00h.
// [RULE10] Read-log is opcode B0h with features D5h.
// [RULE11] Host loads keys, count and log address.
// [RULE12] Transfer always starts at first log sector.
// [RULE13] Decode directory, error, self-test, host, vendor.
// [RULE14] All defined and host logs are implemented.
// [RULE15] Unwritten host logs read as zeros.
// [RULE16] Vendor logs only exist when used.
// [RULE17] Success clears busy, fault, request, error.
// [RULE18] Abort on unsupported, disabled or bad inputs.
// [RULE19] Error bits 6 and 4 for media faults.
// [RULE20] Error bit 2 marks an aborted command.
// [RULE21] Error end sets ready, fault only on fault.
// [RULE22] Host issues only when ready and enabled.
// [RULE23] Zero sector count is aborted.
// [RULE24] Directory is aborted without multi-sector logs.
// [RULE25] Sectors of 512 bytes, request per sector.
`timescale 1ns/1ps
`default_nettype none
module hlr_top
  import hlr_pkg::*;
#(
  parameter logic [15:0] OFF_DURATION  = 16'h0001,
  parameter logic [7:0]  OFF_CAPS      = 8'h1D,
  parameter logic [15:0] HEALTH_CAPS   = 16'h0003,
  parameter bit          MULTI_SECTOR  = 1'b1,
  parameter bit          VENDOR_LOGS   = 1'b0,
  parameter longint      ABORT_LIMIT_CYC = ABORT_LIMIT_S * CLK_HZ
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        offline_active,
  input  wire logic        media_unc,
  input  wire logic        media_id_not_found_flag,
  input  wire logic        fault_in,
  output var  logic        offline_abort,
  output var  logic        offline_suspend
);

  initial begin
    if (OFF_DURATION < OFF_DUR_MIN) $error("Off-line duration must be >0.");
    if (OFF_CAPS[7:5] != 3'b000) $error("Off-line caps bits 7..5 reserved.");
    if (HEALTH_CAPS[15:2] != 14'h0000 || !HEALTH_CAPS[HC_AUTOSAVE])
      $error("Health caps must be 0002h or 0003h.");
    if (ABORT_LIMIT_CYC < 1) $error("Abort limit must be at least 1 cycle.");
  end

  hlr_state_e  state;
  logic [7:0]  features;
  logic [7:0]  sec_cnt;
  logic [7:0]  log_addr;
  logic [7:0]  cyl_lo;
  logic [7:0]  cyl_hi;
  logic [7:0]  dev_head;
  logic        monitor_en;
  logic        busy_flag;
  logic        data_request_flag;
  logic        device_fault_flag;
  logic        uncorrectable_flag;
  logic        id_not_found_flag;
  logic        aborted_flag;
  logic [9:0]  byte_idx;
  logic [7:0]  sect_idx;
  logic [7:0]  sum_acc;

  // Bus handshake: every access waits exactly one cycle.
  wire bus_req   = avs_read | avs_write;
  wire wr_take   = avs_write & ~avs_waitrequest;
  wire rd_take   = avs_read & ~avs_waitrequest;
  wire wr_feat   = wr_take & (avs_address == REG_ERR_FEAT);
  wire wr_cnt    = wr_take & (avs_address == REG_SECCNT);
  wire wr_num    = wr_take & (avs_address == REG_SECNUM);
  wire wr_clo    = wr_take & (avs_address == REG_CYL_LO);
  wire wr_chi    = wr_take & (avs_address == REG_CYL_HI);
  wire wr_dh     = wr_take & (avs_address == REG_DEV_HEAD);
  wire wr_ctl    = wr_take & (avs_address == REG_CONTROL);
  // Task-file writes are ignored while the command runs.
  wire tf_open   = (state == HLR_IDLE);
  wire wr_cmd    = wr_take & (avs_address == REG_STAT_CMD) & tf_open;
  wire [7:0] cmd_byte = avs_writedata[7:0];
  wire data_pop  = rd_take & (avs_address == REG_DATA) & data_request_flag;

  // Log map.
  wire is_dir    = (log_addr == LOG_DIR);
  wire is_errlog = (log_addr == LOG_ERROR);
  wire is_stlog  = (log_addr == LOG_SELFTEST);
  wire is_host   = (log_addr >= LOG_HOST_LO) && (log_addr <= LOG_HOST_HI);
  wire is_vend   = (log_addr >= LOG_VEND_LO) && (log_addr <= LOG_VEND_HI);
  wire log_impl  = (is_dir & MULTI_SECTOR) | is_errlog | is_stlog | is_host
                 | (is_vend & VENDOR_LOGS); // [RULE13] [RULE14] [RULE16] [RULE24]
  wire [4:0] host_len = MULTI_SECTOR ? HOST_SECT_MULTI : 5'h01;
  wire [7:0] log_len  = is_host ? {3'b000, host_len} : 8'h01;

  // Validity of the task file.
  wire keys_ok   = (features == FEAT_READ_LOG) && (cyl_lo == KEY_CYL_LO)
                 && (cyl_hi == KEY_CYL_HI); // [RULE10]
  wire count_ok  = (sec_cnt != 8'h00) && (sec_cnt <= log_len); // [RULE23]
  wire cmd_bad   = ~monitor_en | ~keys_ok | ~count_ok | ~log_impl; // [RULE18]
  wire media_bad = media_unc | media_id_not_found_flag;

  // Sector content.  Host logs have no write path here, so they are
  // always unwritten and read back as zeros.
  wire [6:0] dir_slot  = byte_idx[7:1];
  wire [7:0] dir_entry =
      (byte_idx[9:8] != 2'b00 || byte_idx[0]) ? 8'h00 :
      ({1'b0, dir_slot} == LOG_ERROR)    ? 8'h01 :
      ({1'b0, dir_slot} == LOG_SELFTEST) ? 8'h01 : 8'h00;
  wire [7:0] dir_byte  = (byte_idx == 10'h000) ? LOG_VERSION :
                         (byte_idx >= 10'h100 && byte_idx <= 10'h13F &&
                          !byte_idx[0]) ? {3'b000, host_len} : dir_entry;
  wire [7:0] body_byte = is_dir ? dir_byte :
                         (is_errlog && byte_idx == 10'h000) ? LOG_VERSION :
                         8'h00; // [RULE15]
  wire has_csum = is_errlog | is_stlog;
  wire [7:0] data_byte = (has_csum && byte_idx == SECT_LAST) ?
                         8'(-sum_acc) : body_byte; // [RULE9]
  wire sect_end  = data_pop && (byte_idx == SECT_LAST);
  wire last_sect = (sect_idx == sec_cnt - 8'h01);

  wire [7:0] err_reg  = {1'b0, uncorrectable_flag, 1'b0, id_not_found_flag,
                         1'b0, aborted_flag, 2'b00};
  wire [7:0] stat_reg = {busy_flag, ~busy_flag, device_fault_flag, 1'b0,
                         data_request_flag, 2'b00, (err_reg != 8'h00)};
  wire [31:0] rd_mux =
      (avs_address == REG_DATA)      ? {24'h0000_00, data_byte} :
      (avs_address == REG_ERR_FEAT)  ? {24'h0000_00, err_reg} :
      (avs_address == REG_SECCNT)    ? {24'h0000_00, sec_cnt} :
      (avs_address == REG_SECNUM)    ? {24'h0000_00, log_addr} :
      (avs_address == REG_CYL_LO)    ? {24'h0000_00, cyl_lo} :
      (avs_address == REG_CYL_HI)    ? {24'h0000_00, cyl_hi} :
      (avs_address == REG_DEV_HEAD)  ? {24'h0000_00, dev_head} :
      (avs_address == REG_STAT_CMD)  ? {24'h0000_00, stat_reg} :
      (avs_address == REG_CONTROL)   ? {31'h0000_0000, monitor_en} :
      (avs_address == REG_OFF_CAPS)  ? {8'h00, OFF_CAPS, OFF_DURATION} :
      (avs_address == REG_HLTH_CAPS) ? {16'h0000, HEALTH_CAPS} :
      32'h0000_0000; // [RULE1] [RULE2] [RULE5] [RULE6] [RULE7]

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest) begin
        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      features   <= 8'h00;
      sec_cnt    <= 8'h00;
      log_addr   <= 8'h00;
      cyl_lo     <= 8'h00;
      cyl_hi     <= 8'h00;
      dev_head   <= 8'h00;
      monitor_en <= 1'b0;
    end else begin
      if (wr_feat && tf_open) features <= cmd_byte;
      if (wr_cnt && tf_open) sec_cnt <= cmd_byte;
      if (wr_num && tf_open) log_addr <= cmd_byte;
      if (wr_clo && tf_open) cyl_lo <= cmd_byte;
      if (wr_chi && tf_open) cyl_hi <= cmd_byte;
      if (wr_dh && tf_open) dev_head <= cmd_byte;
      if (wr_ctl) monitor_en <= avs_writedata[0];
    end
  end

  // Off-line collection reacts at once to any command, well inside the
  // abort limit, so no long timer is needed.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      offline_abort   <= 1'b0;
      offline_suspend <= 1'b0;
    end else begin
      offline_abort   <= wr_cmd & offline_active & OFF_CAPS[OC_ABORT_NEW]; // [RULE3]
      offline_suspend <= wr_cmd & offline_active & ~OFF_CAPS[OC_ABORT_NEW]; // [RULE4]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state              <= HLR_IDLE;
      busy_flag          <= 1'b0;
      data_request_flag  <= 1'b0;
      device_fault_flag  <= 1'b0;
      uncorrectable_flag <= 1'b0;
      id_not_found_flag  <= 1'b0;
      aborted_flag       <= 1'b0;
      byte_idx           <= 10'h000;
      sect_idx           <= 8'h00;
      sum_acc            <= 8'h00;
    end else begin
      case (state)
        HLR_IDLE: begin
          if (wr_cmd) begin
            busy_flag          <= 1'b1;
            data_request_flag  <= 1'b0;
            device_fault_flag  <= 1'b0;
            uncorrectable_flag <= 1'b0;
            id_not_found_flag  <= 1'b0;
            aborted_flag       <= 1'b0;
            if (cmd_byte == CMD_HEALTH) begin
              state <= HLR_CHECK;
            end else begin
              busy_flag    <= 1'b0;
              aborted_flag <= 1'b1; // [RULE20]
            end
          end
        end
        HLR_CHECK: begin
          byte_idx <= 10'h000; // [RULE12]
          sect_idx <= 8'h00;
          sum_acc  <= 8'h00;
          busy_flag <= 1'b0;
          if (cmd_bad) begin
            state        <= HLR_IDLE;
            aborted_flag <= 1'b1; // [RULE18] [RULE20] [RULE21]
          end else if (media_bad) begin
            state              <= HLR_IDLE;
            uncorrectable_flag <= media_unc; // [RULE19]
            id_not_found_flag  <= media_id_not_found_flag; // [RULE19]
            device_fault_flag  <= fault_in; // [RULE21]
          end else begin
            state             <= HLR_XFER;
            data_request_flag <= 1'b1; // [RULE25]
          end
        end
        HLR_XFER: begin
          if (data_pop) begin
            byte_idx <= byte_idx + 10'h001;
            sum_acc  <= sum_acc + data_byte;
          end
          if (sect_end) begin
            // A 10-bit index would run past 511, so each sector restarts it.
            byte_idx <= 10'h000; // [RULE25]
            sum_acc  <= 8'h00;
            sect_idx <= sect_idx + 8'h01;
            if (last_sect) begin
              state             <= HLR_IDLE;
              data_request_flag <= 1'b0; // [RULE17] [RULE25]
            end else if (media_bad) begin
              state              <= HLR_IDLE;
              data_request_flag  <= 1'b0; // [RULE21]
              uncorrectable_flag <= media_unc;
              id_not_found_flag  <= media_id_not_found_flag;
              device_fault_flag  <= fault_in;
            end
          end
        end
        default: begin
          state             <= HLR_IDLE;
          busy_flag         <= 1'b0;
          data_request_flag <= 1'b0;
        end
      endcase
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_cmd_read_log;
    wr_cmd && cmd_byte == CMD_HEALTH;
  endsequence

  sequence s_checked_bad;
    state == HLR_CHECK && cmd_bad;
  endsequence

  property p_keys_or_abort;
    s_cmd_read_log ##1 (state == HLR_CHECK && !keys_ok)
      |=> aborted_flag && !data_request_flag && !busy_flag;
  endproperty
  a_keys_or_abort: assert property (p_keys_or_abort) // [RULE10]
    else $error("Bad keys did not abort.");

  property p_bad_aborts;
    s_checked_bad |=> aborted_flag && stat_reg[ST_ERR] && stat_reg[ST_DRIVE_READY_FLAG]
      && !stat_reg[ST_BSY] && !stat_reg[ST_DRQ];
  endproperty
  a_bad_aborts: assert property (p_bad_aborts) // [RULE18]
    else $error("Invalid request not aborted with ready status.");

  property p_zero_count;
    state == HLR_CHECK && sec_cnt == 8'h00 |=> aborted_flag;
  endproperty
  a_zero_count: assert property (p_zero_count) // [RULE23]
    else $error("Zero sector count not aborted.");

  property p_dir_single;
    state == HLR_CHECK && is_dir && !MULTI_SECTOR |=> aborted_flag;
  endproperty
  a_dir_single: assert property (p_dir_single) // [RULE24]
    else $error("Directory read not aborted.");

  property p_start_first;
    state == HLR_CHECK && !cmd_bad && !media_bad
      |=> state == HLR_XFER && byte_idx == 10'h000 && sect_idx == 8'h00
      && data_request_flag && !busy_flag;
  endproperty
  a_start_first: assert property (p_start_first) // [RULE12]
    else $error("Transfer did not start at first sector.");

  property p_host_zero;
    state == HLR_XFER && is_host |-> data_byte == 8'h00;
  endproperty
  a_host_zero: assert property (p_host_zero) // [RULE15]
    else $error("Unwritten host log byte not zero.");

  property p_csum;
    state == HLR_XFER && has_csum && byte_idx == SECT_LAST
      |-> 8'(sum_acc + data_byte) == 8'h00;
  endproperty
  a_csum: assert property (p_csum) // [RULE9]
    else $error("Sector checksum does not sum to zero.");

  property p_success_end;
    sect_end && last_sect |=> state == HLR_IDLE && stat_reg == 8'h40;
  endproperty
  a_success_end: assert property (p_success_end) // [RULE17]
    else $error("Successful end status wrong.");

  property p_offline_react;
    wr_cmd && offline_active
      |=> (offline_abort ^ offline_suspend)
      && offline_abort == OFF_CAPS[OC_ABORT_NEW];
  endproperty
  a_offline_react: assert property (p_offline_react) // [RULE3]
    else $error("Off-line work not stopped as advertised.");

  property p_err_bit;
    uncorrectable_flag || id_not_found_flag || aborted_flag
      |-> stat_reg[ST_ERR] && !stat_reg[ST_BSY] || state != HLR_IDLE;
  endproperty
  a_err_bit: assert property (p_err_bit) // [RULE21]
    else $error("Error status bit not set with error register.");

  property p_sector_wrap;
    sect_end && !last_sect |=> byte_idx == 10'h000 && data_request_flag;
  endproperty
  a_sector_wrap: assert property (p_sector_wrap) // [RULE25]
    else $error("Next sector does not start at byte zero.");

  property p_media_flags;
    state == HLR_CHECK && !cmd_bad && media_bad
      |=> uncorrectable_flag == $past(media_unc)
      && id_not_found_flag == $past(media_id_not_found_flag) && !data_request_flag;
  endproperty
  a_media_flags: assert property (p_media_flags) // [RULE19]
    else $error("Media error not reported in the error register.");

  property p_wait_one;
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("Bus answer not after one wait cycle.");

endmodule // hlr_top
`default_nettype wire

// ==== verif/hlr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hlr_host_model
  import hlr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output var  logic [3:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata
);
  // Settling time the host allows before its first status poll.
  localparam int POLL_WAIT = 2;

  initial begin
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // Released write data is inverted so a stale value is never mistaken.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write     <= 1'b1;
    @(posedge clk_sys iff (avs_waitrequest === 1'b0));
    avs_write     <= 1'b0;
    avs_writedata <= ~{24'h00_0000, d};
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge clk_sys iff (avs_waitrequest === 1'b0));
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // Polls status until busy clears; bounded so a hang still ends.
  task automatic wait_idle(output logic [7:0] st);
    logic [31:0] d;
    st = 8'hFF;
    repeat (POLL_WAIT) @(posedge clk_sys);
    for (int i = 0; i < 40; i++) begin
      rd(REG_STAT_CMD, d);
      st = d[7:0];
      if (st[ST_BSY] === 1'b0) break;
    end
  endtask

  task automatic issue(input logic [7:0] feat, input logic [7:0] cnt,
                       input logic [7:0] log_a, input logic [7:0] cyl_lo,
                       input logic [7:0] cmd);
    logic [7:0] st;
    wait_idle(st);
    wr(REG_ERR_FEAT, feat);
    wr(REG_SECCNT, cnt);
    wr(REG_SECNUM, log_a);
    wr(REG_CYL_LO, cyl_lo);
    wr(REG_CYL_HI, KEY_CYL_HI);
    wr(REG_DEV_HEAD, 8'h00);
    wr(REG_STAT_CMD, cmd);
  endtask
endmodule // hlr_host_model
`default_nettype wire

// ==== verif/test_health_log_read_command.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_health_log_read_command
  import hlr_pkg::*;
;
  logic        clk_sys;
  logic        rst_b;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        offline_active;
  logic        media_unc;
  logic        media_id_not_found_flag;
  logic        fault_in;
  logic        offline_abort;
  logic        offline_suspend;
  int          miscompares;
  int          num_checks;
  int          n_abort;
  int          n_susp;
  logic [7:0]  sect [512];
  logic [31:0] d;
  logic [7:0]  st;

  hlr_top dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .offline_active(offline_active),
    .media_unc(media_unc), .media_id_not_found_flag(media_id_not_found_flag), .fault_in(fault_in),
    .offline_abort(offline_abort), .offline_suspend(offline_suspend)
  );

  hlr_host_model host (
    .clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata)
  );

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (offline_abort === 1'b1) n_abort++;
    if (offline_suspend === 1'b1) n_susp++;
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic get_sector();
    for (int i = 0; i < 512; i++) begin
      host.rd(REG_DATA, d);
      sect[i] = d[7:0];
    end
  endtask

  task automatic t_reset();
    host.rd(REG_STAT_CMD, d);
    chk("status", 32'h0000_0040, d);
    host.rd(REG_ERR_FEAT, d);
    chk("error", 32'h0000_0000, d);
    host.rd(REG_OFF_CAPS, d);
    chk("offline caps", 32'h001D_0001, d);
    host.rd(REG_HLTH_CAPS, d);
    chk("health caps", 32'h0000_0003, d);
    host.rd(4'hB, d);
    chk("unmapped", 32'h0000_0000, d);
    host.wr(REG_CONTROL, 8'h01);
    host.rd(REG_CONTROL, d);
    chk("control", 32'h0000_0001, {31'h0000_0000, d[0]});
  endtask

  task automatic t_error_log();
    logic [7:0] s;
    offline_active <= 1'b1;
    host.issue(FEAT_READ_LOG, 8'h01, LOG_ERROR, KEY_CYL_LO, CMD_HEALTH);
    offline_active <= 1'b0;
    // The pulse is counted one edge after the command write lands.
    host.wait_idle(st);
    chk("abort pulses", 32'h0000_0001, n_abort);
    chk("suspend pulses", 32'h0000_0000, n_susp);
    chk("drq status", 32'h0000_0048, {24'h00_0000, st & 8'hE9});
    get_sector();
    s = 8'h00;
    for (int i = 0; i < 512; i++) s += sect[i];
    chk("log version", 32'h0000_0001, {24'h00_0000, sect[0]});
    chk("checksum", 32'h0000_0000, {24'h00_0000, s});
    host.rd(REG_STAT_CMD, d);
    chk("done status", 32'h0000_0040, d & 32'h0000_00E9);
  endtask

  task automatic t_dir();
    host.issue(FEAT_READ_LOG, 8'h01, LOG_DIR, KEY_CYL_LO, CMD_HEALTH);
    host.wait_idle(st);
    get_sector();
    chk("dir version", 32'h0000_0001, {24'h00_0000, sect[0]});
    chk("dir log1", 32'h0000_0001, {24'h00_0000, sect[2]});
    chk("dir log6", 32'h0000_0001, {24'h00_0000, sect[12]});
    chk("dir host", 32'h0000_0010, {24'h00_0000, sect[256]});
  endtask

  task automatic t_host();
    logic [7:0] acc;
    logic [7:0] la [2] = '{8'h80, 8'h9F};
    logic [7:0] cn [2] = '{8'h02, 8'h01};
    for (int k = 0; k < 2; k++) begin
      acc = 8'h00;
      host.issue(FEAT_READ_LOG, cn[k], la[k], KEY_CYL_LO, CMD_HEALTH);
      for (int j = 0; j < cn[k]; j++) begin
        host.wait_idle(st);
        chk("sector drq", 32'h0000_0048,
            {24'h00_0000, st & 8'hE9});
        get_sector();
        for (int i = 0; i < 512; i++) acc |= sect[i];
      end
      chk("host zeros", 32'h0000_0000, {24'h00_0000, acc});
      host.rd(REG_STAT_CMD, d);
      chk("host end", 32'h0000_0040, d & 32'h0000_00E9);
    end
  endtask

  // Entries are features, count, log address, cylinder low, opcode.
  task automatic t_abort();
    logic [39:0] tb [9] = '{
      40'hD5_0101_4FB0, 40'hD4_0101_4FB0, 40'hD5_0101_4EB0,
      40'hD5_0001_4FB0, 40'hD5_0102_4FB0, 40'hD5_01A0_4FB0,
      40'hD5_0201_4FB0, 40'hD5_0101_4FEC, 40'hD5_01C0_4FB0};
    for (int i = 0; i < 9; i++) begin
      host.wr(REG_CONTROL, (i == 0) ? 8'h00 : 8'h01);
      host.issue(tb[i][39:32], tb[i][31:24], tb[i][23:16], tb[i][15:8],
                 tb[i][7:0]);
      host.wait_idle(st);
      chk("abort status", 32'h0000_0041,
          {24'h00_0000, st & 8'hE9});
      host.rd(REG_ERR_FEAT, d);
      chk("abort error", 32'h0000_0004, d & 32'h0000_00FF);
    end
  endtask

  task automatic t_media();
    logic [7:0] es [2] = '{8'h61, 8'h41};
    logic [7:0] ee [2] = '{8'h40, 8'h10};
    for (int i = 0; i < 2; i++) begin
      media_unc  <= (i == 0);
      fault_in   <= (i == 0);
      media_id_not_found_flag <= (i == 1);
      host.issue(FEAT_READ_LOG, 8'h01, LOG_ERROR, KEY_CYL_LO, CMD_HEALTH);
      host.wait_idle(st);
      chk("media status", {24'h00_0000, es[i]},
          {24'h00_0000, st & 8'hE9});
      host.rd(REG_ERR_FEAT, d);
      chk("media error", {24'h00_0000, ee[i]}, d & 32'h0000_0050);
    end
    media_unc  <= 1'b0;
    fault_in   <= 1'b0;
    media_id_not_found_flag <= 1'b0;
  endtask

  initial begin
    // Some 3000 bus accesses of three cycles each, with ample margin.
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    end_sim();
  end

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    offline_active = 1'b0;
    media_unc = 1'b0;
    media_id_not_found_flag = 1'b0;
    fault_in = 1'b0;
    miscompares = 0;
    num_checks = 0;
    n_abort = 0;
    n_susp = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_error_log();
    t_dir();
    t_host();
    t_abort();
    t_media();
    end_sim();
  end
endmodule // test_health_log_read_command
`default_nettype wire
